//--- shared/vad_pkg.sv
// Shared constants and types for the video averaging decimator
package vad_pkg;
  localparam int SAMPLE_W = 8;
  localparam int HIST_LEN = 7;
  localparam int SUM_W = 11;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int PHASE_W = 3;
  localparam int GAP_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h4;

  // Control register fields
  localparam int CTL_W = 4;
  localparam int CTL_FILTER_BIT = 0;
  localparam int CTL_CDEC_LO_BIT = 1;
  localparam int CTL_CDEC_HI_BIT = 2;
  localparam int CTL_LDEC_BIT = 3;
  localparam logic [CTL_W-1:0] CTL_RESET = 4'h0;

  // Status register fields
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_FILL_BIT = 1;
  localparam int STAT_PHASE_LSB = 4;

  // Phase and fill counts
  localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_AFTER_SYNC = 3'h1;
  localparam logic [PHASE_W-1:0] FILL_DONE = 3'h7;
  localparam logic [GAP_W-1:0] GAP_MAX = 4'hf;

  // Decimation phase masks, factor minus one
  localparam logic [PHASE_W-1:0] MASK_DIV1 = 3'h0;
  localparam logic [PHASE_W-1:0] MASK_DIV2 = 3'h1;
  localparam logic [PHASE_W-1:0] MASK_DIV4 = 3'h3;
  localparam logic [PHASE_W-1:0] MASK_DIV8 = 3'h7;

  typedef enum logic [3:0] {
    VAD_PASS = 4'h1,
    VAD_PAIR = 4'h2,
    VAD_QUAD = 4'h4,
    VAD_OCT = 4'h8
  } vad_mode_t;
endpackage

//--- logic/vad_chan.sv
// One sample channel: history line and mode-selected mean
module vad_chan (
  input wire logic i_clk, // Sampling clock
  input wire logic i_reset, // Async reset, active high
  input wire logic [vad_pkg::SAMPLE_W-1:0] i_sample, // New sample each clock
  input vad_pkg::vad_mode_t i_mode, // Averaging mode
  output logic [vad_pkg::SAMPLE_W-1:0] o_mean // Combinational result
);
  logic [vad_pkg::SAMPLE_W-1:0] hist [0:vad_pkg::HIST_LEN-1];
  logic [vad_pkg::SUM_W-1:0] sum;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < vad_pkg::HIST_LEN; k++) begin
        hist[k] <= 8'h00;
      end
    end else begin
      hist[0] <= i_sample;
      for (int k = 1; k < vad_pkg::HIST_LEN; k++) begin
        hist[k] <= hist[k-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // hist[k] holds the input k+1 clocks back; taps chosen for equal delay
  always_comb begin
    sum = 11'h000;
    case (i_mode)
      vad_pkg::VAD_PASS: sum = {3'h0, hist[2]};
      vad_pkg::VAD_PAIR: sum = {3'h0, hist[3]} + {3'h0, hist[2]};
      vad_pkg::VAD_QUAD: begin
        sum = {3'h0, hist[4]} + {3'h0, hist[3]} + {3'h0, hist[2]} + {3'h0, hist[1]};
      end
      vad_pkg::VAD_OCT: begin
        sum = {3'h0, i_sample};
        for (int k = 0; k < vad_pkg::HIST_LEN; k++) begin
          sum = sum + {3'h0, hist[k]};
        end
      end
      default: sum = {3'h0, hist[2]};
    endcase
  end

  // Fraction bits are simply dropped: no rounding bias correction
  always_comb begin
    case (i_mode)
      vad_pkg::VAD_PAIR: o_mean = sum[8:1];
      vad_pkg::VAD_QUAD: o_mean = sum[9:2];
      vad_pkg::VAD_OCT: o_mean = sum[10:3];
      default: o_mean = sum[7:0];
    endcase
  end
endmodule

//--- logic/vad_top.sv
// Triple-channel averaging and decimation stage with Avalon-MM control
// Operation
// - Three 8-bit streams, one sample per clock
// - Luma mode separate; chroma pair shares mode
// - Luma average of inputs four, three back
// - Chroma two-tap average of four, three back
// - Chroma quad mean of five..two back, fourth
// - Chroma eight-sample mean kept every eighth output
// - Intermediate decimated results are dropped
// - Decimation by two, four or eight on chroma, by two on luma
// - Filter modes share 3.5 clock group delay
// - Unfiltered output is input three clocks back
// - Sample rate follows the applied clock
// - Filtering can be disabled for external decimator
// - First sync high marks first decimated word
// - Filter enable and decimation select controls
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
module vad_top (
  input wire logic i_clk, // 50 MHz sampling clock
  input wire logic i_reset, // Async reset, active high
  input wire logic [7:0] i_luma, // Luminance samples
  input wire logic [7:0] i_chroma_b, // First chrominance samples
  input wire logic [7:0] i_chroma_c, // Second chrominance samples
  input wire logic i_format_phase_sync, // Decimation phase sync
  input wire logic [3:0] i_avs_address, // Byte address
  input wire logic i_avs_read, // Read request
  input wire logic i_avs_write, // Write request
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte lanes
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Stall until answer
  output logic [7:0] o_luma, // Luminance result
  output logic [7:0] o_chroma_b, // First chrominance result
  output logic [7:0] o_chroma_c, // Second chrominance result
  output logic o_luma_strobe, // New luminance word
  output logic o_chroma_strobe // New chrominance pair
);
  logic bus_ack;
  logic ctl_write;
  logic [vad_pkg::CTL_W-1:0] ctl;
  logic filter_enable_pin;
  logic chroma_decim_sel_lo;
  logic chroma_decim_sel_hi;
  logic luma_decim_sel;
  vad_pkg::vad_mode_t luma_mode;
  vad_pkg::vad_mode_t chroma_mode;
  logic [2:0] luma_mask;
  logic [2:0] chroma_mask;
  logic sync_prev;
  logic sync_rise;
  logic synced;
  logic [2:0] phase;
  logic [2:0] cur_phase;
  logic [2:0] fill;
  logic filled;
  logic ready;
  logic luma_keep;
  logic chroma_keep;
  logic [7:0] mean [0:2];
  logic [7:0] samp [0:2];
  vad_pkg::vad_mode_t chan_mode [0:2];

  // Decimation factor select to phase mask
  function automatic logic [2:0] dec_mask(input logic [1:0] sel);
    case (sel)
      2'h0: dec_mask = vad_pkg::MASK_DIV1;
      2'h1: dec_mask = vad_pkg::MASK_DIV2;
      2'h2: dec_mask = vad_pkg::MASK_DIV4;
      default: dec_mask = vad_pkg::MASK_DIV8;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Avalon slave: every access answers on the second edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_ack;
  assign ctl_write = i_avs_write & bus_ack & (i_avs_address == vad_pkg::CTL_ADDR)
    & i_avs_byteenable[0];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (i_avs_read | i_avs_write) & ~bus_ack;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & ~bus_ack) begin
      case (i_avs_address)
        vad_pkg::CTL_ADDR: o_avs_readdata <= {28'h0, ctl};
        vad_pkg::STAT_ADDR: begin
          o_avs_readdata <= {25'h0, phase, 2'h0, filled, synced};
        end
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctl <= vad_pkg::CTL_RESET;
    end else if (ctl_write) begin
      ctl <= i_avs_writedata[vad_pkg::CTL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode decode from control bits
  assign filter_enable_pin = ctl[vad_pkg::CTL_FILTER_BIT];
  assign chroma_decim_sel_lo = ctl[vad_pkg::CTL_CDEC_LO_BIT];
  assign chroma_decim_sel_hi = ctl[vad_pkg::CTL_CDEC_HI_BIT];
  assign luma_decim_sel = ctl[vad_pkg::CTL_LDEC_BIT];
  assign luma_mask = dec_mask({1'b0, luma_decim_sel});
  assign chroma_mask = dec_mask({chroma_decim_sel_hi, chroma_decim_sel_lo});

  always_comb begin
    luma_mode = filter_enable_pin ? vad_pkg::VAD_PAIR : vad_pkg::VAD_PASS;
    chroma_mode = vad_pkg::VAD_PASS;
    if (filter_enable_pin) begin
      // Wide means tied to their decimation, so no illegal pairing exists
      case (chroma_mask)
        vad_pkg::MASK_DIV4: chroma_mode = vad_pkg::VAD_QUAD;
        vad_pkg::MASK_DIV8: chroma_mode = vad_pkg::VAD_OCT;
        default: chroma_mode = vad_pkg::VAD_PAIR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Three channels; both chroma channels take one mode
  assign samp[0] = i_luma;
  assign samp[1] = i_chroma_b;
  assign samp[2] = i_chroma_c;
  assign chan_mode[0] = luma_mode;
  assign chan_mode[1] = chroma_mode;
  assign chan_mode[2] = chroma_mode;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_chan
      vad_chan u_chan (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_sample(samp[g]),
        .i_mode(chan_mode[g]),
        .o_mean(mean[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Phase sync; each new high level restarts the sequence
  assign sync_rise = i_format_phase_sync & ~sync_prev;
  assign cur_phase = sync_rise ? vad_pkg::PHASE_RESET : phase;
  assign filled = (fill == vad_pkg::FILL_DONE);
  assign ready = filled & (synced | sync_rise);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_prev <= 1'b0;
      synced <= 1'b0;
    end else begin
      sync_prev <= i_format_phase_sync;
      synced <= synced | sync_rise;
    end
  end

  // Free running; a sync period of n*8 keeps it aligned
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      phase <= vad_pkg::PHASE_RESET;
    end else if (sync_rise) begin
      phase <= vad_pkg::PHASE_AFTER_SYNC;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fill <= 3'h0;
    end else if (!filled) begin
      fill <= fill + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs hold between kept words, giving relaxed receive timing
  assign luma_keep = (cur_phase & luma_mask) == 3'h0;
  assign chroma_keep = (cur_phase & chroma_mask) == 3'h0;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_luma <= 8'h00;
      o_luma_strobe <= 1'b0;
    end else begin
      o_luma_strobe <= ready & luma_keep;
      if (ready & luma_keep) begin
        o_luma <= mean[0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_chroma_b <= 8'h00;
      o_chroma_c <= 8'h00;
      o_chroma_strobe <= 1'b0;
    end else begin
      o_chroma_strobe <= ready & chroma_keep;
      if (ready & chroma_keep) begin
        o_chroma_b <= mean[1];
        o_chroma_c <= mean[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking vad_cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence vad_rise_s;
    sync_rise && filled;
  endsequence

  sequence vad_first_word_s;
    o_luma_strobe && o_chroma_strobe;
  endsequence

  sync_first_a: assert property (vad_rise_s |=> vad_first_word_s)
    else $error("sync did not yield first output word");

  no_early_a: assert property (!synced && !sync_rise |=> !o_luma_strobe && !o_chroma_strobe)
    else $error("output strobe before format sync");

  luma_pass_a: assert property (o_luma_strobe && $past(luma_mode) == vad_pkg::VAD_PASS
    |-> o_luma == $past(i_luma, 4))
    else $error("unfiltered luma not three clocks back");

  luma_pair_a: assert property (o_luma_strobe && $past(luma_mode) == vad_pkg::VAD_PAIR
    |-> o_luma == 8'(({1'b0, $past(i_luma, 4)} + {1'b0, $past(i_luma, 5)}) >> 1))
    else $error("luma pair average wrong");

  chroma_pair_a: assert property (o_chroma_strobe
    && $past(chroma_mode) == vad_pkg::VAD_PAIR
    |-> o_chroma_c == 8'(({1'b0, $past(i_chroma_c, 4)} + {1'b0, $past(i_chroma_c, 5)}) >> 1))
    else $error("chroma pair average wrong");

  chroma_quad_a: assert property (o_chroma_strobe
    && $past(chroma_mode) == vad_pkg::VAD_QUAD
    |-> o_chroma_b == 8'(({2'h0, $past(i_chroma_b, 3)} + {2'h0, $past(i_chroma_b, 4)}
      + {2'h0, $past(i_chroma_b, 5)} + {2'h0, $past(i_chroma_b, 6)}) >> 2))
    else $error("chroma four sample mean wrong");

  chroma_oct_a: assert property (o_chroma_strobe
    && $past(chroma_mode) == vad_pkg::VAD_OCT
    |-> o_chroma_b == 8'(({3'h0, $past(i_chroma_b, 1)} + {3'h0, $past(i_chroma_b, 2)}
      + {3'h0, $past(i_chroma_b, 3)} + {3'h0, $past(i_chroma_b, 4)}
      + {3'h0, $past(i_chroma_b, 5)} + {3'h0, $past(i_chroma_b, 6)}
      + {3'h0, $past(i_chroma_b, 7)} + {3'h0, $past(i_chroma_b, 8)}) >> 3))
    else $error("chroma eight sample mean wrong");

  // Disabled filter leaves a pure delay on the chroma pair
  filter_off_a: assert property (o_chroma_strobe && !$past(filter_enable_pin)
    |-> o_chroma_b == $past(i_chroma_b, 4) && o_chroma_c == $past(i_chroma_c, 4))
    else $error("chroma filtered while disabled");

  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("bus answer late");

  // Spacing between kept words equals the decimation factor
  generate
    for (genvar s = 0; s < 2; s++) begin : g_gap
      logic strobe;
      logic [2:0] mask;
      logic [3:0] gap;
      logic quiet;
      logic ctl_late;
      assign strobe = (s == 0) ? o_luma_strobe : o_chroma_strobe;
      assign mask = (s == 0) ? luma_mask : chroma_mask;
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          gap <= 4'h0;
          quiet <= 1'b0;
          ctl_late <= 1'b0;
        end else begin
          gap <= strobe ? 4'h1 : (gap == vad_pkg::GAP_MAX ? gap : gap + 4'h1);
          ctl_late <= ctl_write;
          // A word launched on the old phase or mask is no reference
          quiet <= (strobe | quiet) & ~sync_rise & ~ctl_write & ~ctl_late;
        end
      end
      decim_gap_a: assert property (strobe && quiet |-> gap == {1'b0, mask} + 4'h1)
        else $error("decimated word spacing wrong");
    end
  endgenerate
endmodule

//--- tb/vad_sink.sv
// Downstream coding stage model: issues phase sync, counts kept words
module vad_sink (
  input wire logic i_clk, // Sampling clock
  input wire logic i_reset, // Async reset, active high
  input wire logic i_enable, // Sync generation on
  input wire logic i_luma_strobe, // New luminance word
  input wire logic i_chroma_strobe, // New chrominance pair
  output logic o_sync, // Format phase sync
  output logic [15:0] o_words // Words taken so far
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt;
  // Restart on enable so the first rise lands at any phase
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt <= 6'h0;
      o_sync <= 1'b0;
    end else if (!i_enable) begin
      cnt <= 6'h0;
      o_sync <= 1'b0;
    end else begin
      cnt <= cnt + 6'h1;
      o_sync <= (cnt < 6'h04); // Period of 64 clocks
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_words <= 16'h0;
    end else begin
      o_words <= o_words + 16'(i_luma_strobe) + 16'(i_chroma_strobe);
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the averaging decimator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int e; logic [7:0] a; logic [7:0] b;} vad_exp_t;
  logic i_clk = 1'b0, i_reset = 1'b1, sync, ps = 1'b0, synced = 1'b0;
  logic run = 1'b0, sync_en = 1'b0, lhit, chit;
  logic [7:0] i_luma = 8'h0, i_chroma_b = 8'h0, i_chroma_c = 8'h0, o_luma, o_chroma_b, o_chroma_c;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'h0, mctl = 4'h0;
  logic i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest, o_luma_strobe, o_chroma_strobe;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic [15:0] words;
  logic [2:0] ph = 3'h0;
  logic [7:0] h [3][256];
  vad_exp_t lq[$], cq[$], x;
  int n_fail = 0, n_checks = 0, ecnt = 0, m, s;

  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) ecnt <= ecnt + 1;

  vad_top u_vad_top (.i_clk(i_clk), .i_reset(i_reset), .i_luma(i_luma),
    .i_chroma_b(i_chroma_b), .i_chroma_c(i_chroma_c), .i_format_phase_sync(sync),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_luma(o_luma),
    .o_chroma_b(o_chroma_b), .o_chroma_c(o_chroma_c), .o_luma_strobe(o_luma_strobe),
    .o_chroma_strobe(o_chroma_strobe));
  vad_sink u_vad_sink (.i_clk(i_clk), .i_reset(i_reset), .i_enable(sync_en),
    .i_luma_strobe(o_luma_strobe), .i_chroma_strobe(o_chroma_strobe), .o_sync(sync),
    .o_words(words));

  ////////////////////////////////////////
  task close_out;
    $display("checks %0d, failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk_data(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Mean of 1, 2, 4 or 8 taps, truncated
  function logic [7:0] mean(input int ch, input int e, input int md);
    int sum;
    int k;
    sum = 0;
    for (k = 0; k < (1 << md); k++) sum += h[ch][(e - k - (md == 3 ? 0 : (md == 2 ? 2 : 3))) & 255];
    return 8'(sum >> md);
  endfunction

  ////////////////////////////////////////
  // One clock: note results due at the next edge, then drive fresh samples
  task step;
    int lm;
    int cm;
    int k;
    @(posedge i_clk);
    if (sync && !ps) begin
      ph = 3'h0;
      synced = 1'b1;
    end else ph = ph + 3'h1;
    ps = sync;
    lm = mctl[0] ? 1 : 0;
    cm = !mctl[0] ? 0 : (mctl[2:1] == 2'b11 ? 3 : (mctl[2:1] == 2'b10 ? 2 : 1));
    if (synced && (ph & {2'b00, mctl[3]}) == 3'h0)
      lq.push_back('{ecnt + 1, mean(0, ecnt, lm), 8'h0});
    if (synced && (ph & 3'((1 << mctl[2:1]) - 1)) == 3'h0)
      cq.push_back('{ecnt + 1, mean(1, ecnt, cm), mean(2, ecnt, cm)});
    for (k = 0; k < 3; k++) h[k][(ecnt + 1) & 255] = 8'($urandom);
    i_luma <= h[0][(ecnt + 1) & 255];
    i_chroma_b <= h[1][(ecnt + 1) & 255];
    i_chroma_c <= h[2][(ecnt + 1) & 255];
  endtask
  task bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd, input logic [3:0] be);
    int n;
    i_avs_address <= addr;
    i_avs_writedata <= wd;
    i_avs_byteenable <= be;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      step();
      if (o_avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      n_fail++;
      $display("[FAIL] waitrequest expected 0 seen 1");
      close_out();
    end else begin
      rd = o_avs_readdata;
      if (wr && addr == vad_pkg::CTL_ADDR && be[0]) mctl = wd[3:0];
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      step();
    end
  endtask

  ////////////////////////////////////////
  always @(posedge i_clk) begin
    if (run) begin
      lhit = lq.size() > 0 && lq[0].e == ecnt;
      chit = cq.size() > 0 && cq[0].e == ecnt;
      chk_data("o_luma_strobe", {7'h0, lhit}, {7'h0, o_luma_strobe});
      chk_data("o_chroma_strobe", {7'h0, chit}, {7'h0, o_chroma_strobe});
      if (lhit) begin
        x = lq.pop_front();
        chk_data("o_luma", x.a, o_luma);
      end
      if (chit) begin
        x = cq.pop_front();
        chk_data("o_chroma_b", x.a, o_chroma_b);
        chk_data("o_chroma_c", x.b, o_chroma_c);
      end
    end
  end

  initial begin
    s = $urandom(32'had1fc90b);
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    run <= 1'b1;
    bus(1'b0, vad_pkg::CTL_ADDR, 32'h0, 4'hf);
    chk_reg("ctrl", 32'h0, rd);
    repeat (30) step();
    // Every control code, each resynced at an odd offset half the time
    for (m = 0; m < 16; m++) begin
      sync_en <= !m[0];
      repeat (m + 1) step();
      sync_en <= 1'b1;
      bus(1'b1, vad_pkg::CTL_ADDR, {28'($urandom), 4'(m)}, 4'h1);
      bus(1'b0, vad_pkg::CTL_ADDR, 32'h0, 4'hf);
      chk_reg("ctrl", {28'h0, 4'(m)}, rd);
      repeat (40) step();
    end
    bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk_reg("unmapped", 32'h0, rd);
    bus(1'b1, vad_pkg::CTL_ADDR, 32'h5, 4'he);
    bus(1'b0, vad_pkg::CTL_ADDR, 32'h0, 4'hf);
    chk_reg("ctrl", 32'hf, rd);
    bus(1'b0, vad_pkg::STAT_ADDR, 32'h0, 4'hf);
    chk_reg("status", 32'h3, rd & 32'h3);
    repeat (10) step();
    chk_reg("sink words", 32'h1, {31'h0, words != 16'h0});
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    $display("[FAIL] run expected end seen timeout");
    close_out();
  end
endmodule
